// >>> tb/test_vertical_timing_config_regs.sv
// Purpose: Self-checking bench for the vertical timing config registers
// Assumes: Inputs change on the falling edge of REF_CLK
// Notes:   Output-mux and field-trigger cases run from tables, the rest by hand
`timescale 1ns/10ps
module test_vertical_timing_config_regs;
	typedef struct packed
	{
		logic [15:0] mux;
		logic [24:0] pol;
		logic [1:0]  st;
		logic        oc;
		logic [5:0]  src;
		logic [3:0]  want;
	} vtc_row_t;
	logic        REF_CLK, RST_N, SER_CLK, SER_DATA, SER_LOAD_N, FIELD_SYNC;
	logic        OUTPUT_CONTROL_INPUT, SUBSTRATE_CLOCK_IN, BASE_SHUTTER;
	logic        SHUTTER_ONE, SHUTTER_TWO, FIRST_BIAS_SIGNAL, STROBE_IN;
	logic        SECOND_BIAS_SIGNAL, SUBSTRATE_CLOCK, FIRST_BIAS_OUT;
	logic        SECOND_BIAS_OUT, MECHANICAL_SHUTTER, STROBE_OUT, TEST_BIT_B;
	logic        FIELD_TRIGGER_PULSE, SWEEP_COUNTER_EXTENSION;
	logic [2:0]  FIELD_TOTAL, FIELD_COUNT;
	logic [1:0]  STANDBY_STATE;
	logic [21:0] STANDBY12_POLARITY, chan;
	logic [12:0] VERT_CHANNEL_IN, VERT_CHANNEL_OUT;
	logic [7:0]  SENSOR_GATE_IN, SENSOR_GATE_OUT;
	logic [4:0]  PATTERN_GROUP_TOTAL, SEQUENCE_TOTAL;
	logic [9:0]  STARTUP_CONFIG_FIELD;
	logic [11:0] TEST_FIELD_A;
	logic [3:0]  trig;
	int          mismatches, comparisons, cnt;
	logic [6:0]  ftab [4] = '{7'h7e, 7'h76, 7'h08, 7'h3a};
	vtc_row_t    rows [10] = '{
		'{16'h0300, 25'h0000000, 2'h0, 1'b1, 6'h2d, 4'hb},
		'{16'h3300, 25'h0000000, 2'h0, 1'b1, 6'h2d, 4'h7},
		'{16'h8300, 25'h0000000, 2'h0, 1'b1, 6'h2d, 4'h9},
		'{16'h4abc, 25'h0000000, 2'h0, 1'b1, 6'h2d, 4'hb},
		'{16'h0300, 25'h152a5a5, 2'h3, 1'b1, 6'h2d, 4'hd},
		'{16'h0300, 25'h0ad5a5a, 2'h2, 1'b1, 6'h2d, 4'h2},
		'{16'h0300, 25'h152a5a5, 2'h0, 1'b0, 6'h2d, 4'hd},
		'{16'h0300, 25'h0ad5a5a, 2'h1, 1'b1, 6'h2d, 4'h2},
		'{16'hb300, 25'h152a5a5, 2'h3, 1'b0, 6'h12, 4'hd},
		'{16'hb300, 25'h0000000, 2'h0, 1'b1, 6'h12, 4'h4}};

	vtc_host i_vtc_host (.clk(REF_CLK), .ser_clk(SER_CLK), .ser_data(SER_DATA),
		.ser_load_n(SER_LOAD_N));
	vtc_config_regs i_vtc_config_regs (.*);

	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		comparisons++;
		if (seen !== want)
		begin
			mismatches++;
			$display("MISMATCH at %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task automatic do_reset();
		@(negedge REF_CLK);
		RST_N = 1'b0;
		cnt = 0;
		repeat (10) @(negedge REF_CLK);
		check({SUBSTRATE_CLOCK, SENSOR_GATE_OUT, VERT_CHANNEL_OUT,
			FIRST_BIAS_OUT, SECOND_BIAS_OUT, MECHANICAL_SHUTTER, STROBE_OUT,
			FIELD_TRIGGER_PULSE}, 40'h0);
		RST_N = 1'b1;
		@(negedge REF_CLK);
		check({PATTERN_GROUP_TOTAL, SEQUENCE_TOTAL, SWEEP_COUNTER_EXTENSION,
			STARTUP_CONFIG_FIELD, TEST_FIELD_A, TEST_BIT_B, FIELD_COUNT},
			{23'h0, 12'h300, 4'h0});
		$display("reset test done");
	endtask : do_reset
	task automatic fsync();
		@(negedge REF_CLK);
		FIELD_SYNC = 1'b1;
		@(negedge REF_CLK);
		FIELD_SYNC = 1'b0;
		cnt = (FIELD_TOTAL == 3'h0 || cnt >= int'(FIELD_TOTAL) - 1)
			? 0 : cnt + 1;
		check({FIELD_COUNT, FIELD_TRIGGER_PULSE},
			{cnt[2:0], trig[3] && cnt[2:0] == trig[2:0]});
	endtask : fsync

	initial
	begin
		REF_CLK = 1'b0;
		forever #4 REF_CLK = ~REF_CLK;
	end
	initial
	begin
		repeat (100000) @(posedge REF_CLK);
		mismatches++;
		report_and_stop();
	end
	initial
	begin
		RST_N = 1'b0;
		FIELD_SYNC = 1'b0;
		FIELD_TOTAL = 3'h7;
		STANDBY_STATE = 2'h0;
		OUTPUT_CONTROL_INPUT = 1'b1;
		STANDBY12_POLARITY = 22'h2c3d1e;
		VERT_CHANNEL_IN = 13'h1a5b;
		SENSOR_GATE_IN = 8'h3c;
		SUBSTRATE_CLOCK_IN = 1'b1;
		{BASE_SHUTTER, SHUTTER_ONE, SHUTTER_TWO, FIRST_BIAS_SIGNAL,
			SECOND_BIAS_SIGNAL, STROBE_IN} = 6'h00;
		trig = 4'h0;
		mismatches = 0;
		comparisons = 0;
		cnt = 0;
		do_reset();
		i_vtc_host.startup();
		check({SWEEP_COUNTER_EXTENSION, STARTUP_CONFIG_FIELD}, 11'h060);
		i_vtc_host.write(vtc_pkg::OFF_SWEEP_EXT, 28'h0000001);
		check({SWEEP_COUNTER_EXTENSION, STARTUP_CONFIG_FIELD}, 11'h460);
		for (int i = 0; i < 10; i++)
		begin
			i_vtc_host.write(vtc_pkg::OFF_SUB_MUX, {12'h000, rows[i].mux});
			i_vtc_host.write(vtc_pkg::OFF_STBY3_POL, {3'h0, rows[i].pol});
			STANDBY_STATE = rows[i].st;
			OUTPUT_CONTROL_INPUT = rows[i].oc;
			{BASE_SHUTTER, SHUTTER_ONE, SHUTTER_TWO, FIRST_BIAS_SIGNAL,
				SECOND_BIAS_SIGNAL, STROBE_IN} = rows[i].src;
			repeat (2) @(negedge REF_CLK);
			chan = rows[i].st == 2'h3 ? rows[i].pol[21:0] :
				(rows[i].st != 2'h0 || !rows[i].oc) ? STANDBY12_POLARITY :
				{SUBSTRATE_CLOCK_IN, SENSOR_GATE_IN, VERT_CHANNEL_IN};
			check({FIRST_BIAS_OUT, SECOND_BIAS_OUT, MECHANICAL_SHUTTER,
				STROBE_OUT}, rows[i].want);
			check({SUBSTRATE_CLOCK, SENSOR_GATE_OUT, VERT_CHANNEL_OUT}, chan);
			check({TEST_FIELD_A, TEST_BIT_B}, {rows[i].mux[11:0], 1'b0});
			$display("row %0d done", i);
		end
		i_vtc_host.write(vtc_pkg::OFF_PAT_TOTAL, 28'h000001f);
		i_vtc_host.write(vtc_pkg::OFF_SEQ_TOTAL, 28'h0000015);
		check({PATTERN_GROUP_TOTAL, SEQUENCE_TOTAL}, 10'h000);
		fsync();
		check({PATTERN_GROUP_TOTAL, SEQUENCE_TOTAL}, 10'h3f5);
		$display("field sync test done");
		for (int k = 0; k < 4; k++)
		begin
			{FIELD_TOTAL, trig} = ftab[k];
			i_vtc_host.write(vtc_pkg::OFF_FTRIG_CTRL, {24'h000000, trig});
			repeat (7) fsync();
		end
		$display("field trigger test done");
		i_vtc_host.write(12'h092, 28'h000000a);
		fsync();
		check({PATTERN_GROUP_TOTAL, SEQUENCE_TOTAL}, 10'h3f5);
		$display("unmapped write test done");
		do_reset();
		report_and_stop();
	end
endmodule : test_vertical_timing_config_regs

bind vtc_config_regs vtc_config_regs_asserts i_vtc_config_regs_asserts (.*);

// >>> tb/vtc_config_regs_asserts.sv
// Purpose: Port-level checks for vtc_config_regs
// Assumes: One REF_CLK domain, RST_N synchronous active low
// Notes:   Sees top ports only
`timescale 1ns/10ps
module vtc_config_regs_asserts
(
	input wire logic        REF_CLK,
	input wire logic        RST_N,
	input wire logic        FIELD_SYNC,
	input wire logic [2:0]  FIELD_TOTAL,
	input wire logic [1:0]  STANDBY_STATE,
	input wire logic        OUTPUT_CONTROL_INPUT,
	input wire logic [12:0] VERT_CHANNEL_IN,
	input wire logic [7:0]  SENSOR_GATE_IN,
	input wire logic        STROBE_IN,
	input wire logic [12:0] VERT_CHANNEL_OUT,
	input wire logic [7:0]  SENSOR_GATE_OUT,
	input wire logic        FIRST_BIAS_OUT,
	input wire logic        SECOND_BIAS_OUT,
	input wire logic        STROBE_OUT,
	input wire logic        FIELD_TRIGGER_PULSE,
	input wire logic [2:0]  FIELD_COUNT,
	input wire logic [4:0]  PATTERN_GROUP_TOTAL,
	input wire logic [4:0]  SEQUENCE_TOTAL
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	a_trig_sync: assert property (
		FIELD_TRIGGER_PULSE |-> $past(FIELD_SYNC))
		else $error("field trigger without field sync");
	a_trig_width: assert property (
		FIELD_TRIGGER_PULSE && !FIELD_SYNC |=> !FIELD_TRIGGER_PULSE)
		else $error("field trigger longer than one cycle");
	a_count_step: assert property (
		$past(FIELD_SYNC) |-> FIELD_COUNT == (($past(FIELD_TOTAL) == 3'h0 ||
		$past(FIELD_COUNT) >= $past(FIELD_TOTAL) - 3'h1) ? 3'h0 :
		$past(FIELD_COUNT) + 3'h1))
		else $error("field counter stepped wrongly");
	a_count_hold: assert property (
		$past(RST_N) && !$past(FIELD_SYNC) |-> $stable(FIELD_COUNT))
		else $error("field counter moved without field sync");
	a_active_hold: assert property (
		$past(RST_N) && !$past(FIELD_SYNC) |->
		$stable({PATTERN_GROUP_TOTAL, SEQUENCE_TOTAL}))
		else $error("field-sync register changed off boundary");
	a_stby_bias: assert property (
		$past(RST_N && (STANDBY_STATE != 2'h0 || !OUTPUT_CONTROL_INPUT))
		|-> FIRST_BIAS_OUT == SECOND_BIAS_OUT)
		else $error("bias outputs differ in standby");
	a_strobe_pass: assert property (
		$past(RST_N && STANDBY_STATE == 2'h0 && OUTPUT_CONTROL_INPUT)
		|-> STROBE_OUT == $past(STROBE_IN))
		else $error("strobe not passed in normal mode");
	a_chan_pass: assert property (
		$past(RST_N && STANDBY_STATE == 2'h0 && OUTPUT_CONTROL_INPUT) |->
		{SENSOR_GATE_OUT, VERT_CHANNEL_OUT} ==
		$past({SENSOR_GATE_IN, VERT_CHANNEL_IN}))
		else $error("channels not passed in normal mode");

	c_trig: cover property (FIELD_TRIGGER_PULSE);
	c_stby3: cover property (STANDBY_STATE == 2'h3);
	c_wrap: cover property ($past(FIELD_SYNC) && FIELD_COUNT == 3'h0);
endmodule : vtc_config_regs_asserts

// >>> tb/vtc_host.sv
// Purpose: Host model driving the three-wire serial write port
// Assumes: Host changes pins on the falling edge of clk
// Notes:   Data line inverted once the frame is released
`timescale 1ns/10ps
module vtc_host
(
	input  wire logic clk,
	output logic      ser_clk,
	output logic      ser_data,
	output logic      ser_load_n
);
	initial
	begin
		ser_clk    = 1'b0;
		ser_data   = 1'b0;
		ser_load_n = 1'b1;
	end
	task automatic write(input logic [11:0] a, input logic [27:0] d);
		logic [39:0] w;
		w = {d, a};
		if (a == vtc_pkg::OFF_SUB_MUX)
			w[26] = 1'b0;
		@(negedge clk);
		ser_load_n = 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			ser_data = w[i];
			ser_clk  = 1'b0;
			@(negedge clk);
			ser_clk = 1'b1;
			@(negedge clk);
		end
		ser_clk    = 1'b0;
		ser_load_n = 1'b1;
		ser_data   = ~ser_data;
		repeat (5) @(negedge clk);
	endtask : write
	task automatic startup();
		write(vtc_pkg::OFF_STARTUP, 28'h0000060);
	endtask : startup
endmodule : vtc_host

// >>> verilog/vtc_config_regs.sv
// Purpose: Vertical timing configuration registers and output merging
// Assumes: All inputs synchronous to REF_CLK (125 MHz); FIELD_SYNC is a pulse
// Notes:   Serial interface is write only
//
// Summary of operation
// - Pattern group total, five bits, takes effect at next field sync.
// - Sequence total, five bits, resets to zero, updated at field sync.
// - Standby three drives vertical, gate, substrate clock outputs to polarity.
// - Bias, shutter, strobe levels apply in any standby or output control low.
// - Sweep extension bit selects legacy or extra toggles after sweep repeats.
// - Select bit 12 picks first bias signal or base shutter XOR it.
// - Select bit 13 picks second bias signal or base shutter XOR it.
// - Select bit 15 picks shutter one or two to XOR with base shutter.
// - Field trigger pulses in the field whose count matches bits 2 to 0.
// - Field trigger reaches the output only while bit 3 is set.
// - Mode field counter cycles through programmed field total, at most seven.
`timescale 1ns/10ps
module vtc_config_regs
#(
	parameter int unsigned DATA_BITS = vtc_pkg::DATA_W
)
(
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	input  wire logic        SER_CLK,
	input  wire logic        SER_DATA,
	input  wire logic        SER_LOAD_N,
	input  wire logic        FIELD_SYNC,
	input  wire logic [2:0]  FIELD_TOTAL,
	input  wire logic [1:0]  STANDBY_STATE,
	input  wire logic        OUTPUT_CONTROL_INPUT,
	input  wire logic [21:0] STANDBY12_POLARITY,
	input  wire logic [12:0] VERT_CHANNEL_IN,
	input  wire logic [7:0]  SENSOR_GATE_IN,
	input  wire logic        SUBSTRATE_CLOCK_IN,
	input  wire logic        BASE_SHUTTER,
	input  wire logic        SHUTTER_ONE,
	input  wire logic        SHUTTER_TWO,
	input  wire logic        FIRST_BIAS_SIGNAL,
	input  wire logic        SECOND_BIAS_SIGNAL,
	input  wire logic        STROBE_IN,
	output logic [12:0]      VERT_CHANNEL_OUT,
	output logic [7:0]       SENSOR_GATE_OUT,
	output logic             SUBSTRATE_CLOCK,
	output logic             FIRST_BIAS_OUT,
	output logic             SECOND_BIAS_OUT,
	output logic             MECHANICAL_SHUTTER,
	output logic             STROBE_OUT,
	output logic             FIELD_TRIGGER_PULSE,
	output logic [2:0]       FIELD_COUNT,
	output logic [4:0]       PATTERN_GROUP_TOTAL,
	output logic [4:0]       SEQUENCE_TOTAL,
	output logic             SWEEP_COUNTER_EXTENSION,
	output logic [9:0]       STARTUP_CONFIG_FIELD,
	output logic [11:0]      TEST_FIELD_A,
	output logic             TEST_BIT_B
);
	logic                            wr_pulse;
	logic [vtc_pkg::ADDR_W-1:0]      wr_addr;
	logic [DATA_BITS-1:0]            wr_data;
	logic [4:0]                      pat_shadow_reg;
	logic [4:0]                      seq_shadow_reg;
	logic [24:0]                     stby3_pol_reg;
	logic [15:0]                     sub_mux_reg;
	logic [3:0]                      ftrig_ctrl_reg;
	logic [2:0]                      field_cnt_next;
	logic                            in_standby;
	logic                            hold_levels;
	logic                            bias0_mux;
	logic                            bias1_mux;
	logic                            shut_mux;
	logic [21:0]                     chan_func;
	logic [21:0]                     chan_sel;

	function automatic logic hit(input logic [11:0] off);
		hit = wr_pulse && wr_addr == off;
	endfunction : hit

	vtc_serial_rx #(.DATA_BITS(DATA_BITS)) u_rx
	(
		.clk      (REF_CLK),
		.rst_n    (RST_N),
		.sck      (SER_CLK),
		.sdata    (SER_DATA),
		.sload_n  (SER_LOAD_N),
		.wr_pulse (wr_pulse),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data)
	);

	// Field-sync shadows: written copy held until the boundary
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			pat_shadow_reg <= vtc_pkg::RST_PAT_TOTAL;
			seq_shadow_reg <= vtc_pkg::RST_SEQ_TOTAL;
		end
		else
		begin
			if (hit(vtc_pkg::OFF_PAT_TOTAL))
				pat_shadow_reg <= wr_data[4:0];
			if (hit(vtc_pkg::OFF_SEQ_TOTAL))
				seq_shadow_reg <= wr_data[4:0];
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			PATTERN_GROUP_TOTAL <= vtc_pkg::RST_PAT_TOTAL;
			SEQUENCE_TOTAL      <= vtc_pkg::RST_SEQ_TOTAL;
		end
		else if (FIELD_SYNC)
		begin
			PATTERN_GROUP_TOTAL <= pat_shadow_reg;
			SEQUENCE_TOTAL      <= seq_shadow_reg;
		end
	end

	// serial-clock registers act on the completed write
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			stby3_pol_reg           <= vtc_pkg::RST_STBY3_POL;
			SWEEP_COUNTER_EXTENSION <= vtc_pkg::RST_SWEEP_EXT;
			STARTUP_CONFIG_FIELD    <= vtc_pkg::RST_STARTUP;
			sub_mux_reg             <= vtc_pkg::RST_SUB_MUX;
			ftrig_ctrl_reg          <= vtc_pkg::RST_FTRIG_CTRL;
		end
		else
		begin
			if (hit(vtc_pkg::OFF_STBY3_POL))
				stby3_pol_reg <= wr_data[24:0];
			// extension bit steers the vertical counters
			if (hit(vtc_pkg::OFF_SWEEP_EXT))
				SWEEP_COUNTER_EXTENSION <= wr_data[0];
			if (hit(vtc_pkg::OFF_STARTUP))
				STARTUP_CONFIG_FIELD <= wr_data[9:0];
			if (hit(vtc_pkg::OFF_SUB_MUX))
				sub_mux_reg <= wr_data[15:0];
			if (hit(vtc_pkg::OFF_FTRIG_CTRL))
				ftrig_ctrl_reg <= wr_data[3:0];
		end
	end

	// test fields passed out as written
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			TEST_FIELD_A <= vtc_pkg::RST_SUB_MUX[11:0];
			TEST_BIT_B   <= vtc_pkg::RST_SUB_MUX[vtc_pkg::MUX_TEST_BIT];
		end
		else
		begin
			TEST_FIELD_A <= sub_mux_reg[11:0];
			TEST_BIT_B   <= sub_mux_reg[vtc_pkg::MUX_TEST_BIT];
		end
	end

	// counter wraps after the programmed number of fields
	always_comb
	begin
		if (FIELD_TOTAL == 3'h0 || FIELD_COUNT >= FIELD_TOTAL - 3'h1)
			field_cnt_next = 3'h0;
		else
			field_cnt_next = FIELD_COUNT + 3'h1;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			FIELD_COUNT <= 3'h0;
		else if (FIELD_SYNC)
			FIELD_COUNT <= field_cnt_next;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			FIELD_TRIGGER_PULSE <= 1'b0;
		else
			// pulse in matching field, only when enabled
			FIELD_TRIGGER_PULSE <= FIELD_SYNC
				&& field_cnt_next == ftrig_ctrl_reg[2:0]
				&& ftrig_ctrl_reg[vtc_pkg::FTRIG_ENABLE];
	end

	assign in_standby  = STANDBY_STATE != vtc_pkg::STBY_NONE;
	assign hold_levels = in_standby || !OUTPUT_CONTROL_INPUT;
	assign bias0_mux = sub_mux_reg[vtc_pkg::MUX_BIAS0_SEL]
		? BASE_SHUTTER ^ FIRST_BIAS_SIGNAL : FIRST_BIAS_SIGNAL;
	assign bias1_mux = sub_mux_reg[vtc_pkg::MUX_BIAS1_SEL]
		? BASE_SHUTTER ^ SECOND_BIAS_SIGNAL : SECOND_BIAS_SIGNAL;
	assign shut_mux = BASE_SHUTTER ^ (sub_mux_reg[vtc_pkg::MUX_SHUT_SEL]
		? SHUTTER_TWO : SHUTTER_ONE);
	assign chan_func = {SUBSTRATE_CLOCK_IN, SENSOR_GATE_IN, VERT_CHANNEL_IN};

	// standby three uses its own polarity, others the outside set
	always_comb
	begin
		if (STANDBY_STATE == vtc_pkg::STBY_THREE)
			chan_sel = stby3_pol_reg[21:0];
		else if (hold_levels)
			chan_sel = STANDBY12_POLARITY;
		else
			chan_sel = chan_func;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			VERT_CHANNEL_OUT <= 13'h0000;
			SENSOR_GATE_OUT  <= 8'h00;
			SUBSTRATE_CLOCK  <= 1'b0;
		end
		else
		begin
			VERT_CHANNEL_OUT <= chan_sel[vtc_pkg::POL_GATE_LSB-1:0];
			SENSOR_GATE_OUT  <= chan_sel[vtc_pkg::POL_SUBCK-1:
				vtc_pkg::POL_GATE_LSB];
			SUBSTRATE_CLOCK  <= chan_sel[vtc_pkg::POL_SUBCK];
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			FIRST_BIAS_OUT     <= 1'b0;
			SECOND_BIAS_OUT    <= 1'b0;
			MECHANICAL_SHUTTER <= 1'b0;
			STROBE_OUT         <= 1'b0;
		end
		else if (hold_levels)
		begin
			// fixed levels in any standby or output control low
			FIRST_BIAS_OUT     <= stby3_pol_reg[vtc_pkg::POL_BIAS];
			SECOND_BIAS_OUT    <= stby3_pol_reg[vtc_pkg::POL_BIAS];
			MECHANICAL_SHUTTER <= stby3_pol_reg[vtc_pkg::POL_MECHANICAL_SHUTTER];
			STROBE_OUT         <= stby3_pol_reg[vtc_pkg::POL_STROBE];
		end
		else
		begin
			FIRST_BIAS_OUT     <= bias0_mux;
			SECOND_BIAS_OUT    <= bias1_mux;
			MECHANICAL_SHUTTER <= shut_mux;
			STROBE_OUT         <= STROBE_IN;
		end
	end
endmodule : vtc_config_regs

// >>> verilog/vtc_pkg.sv
// Purpose: Shared constants for the vertical timing configuration registers
// Assumes: Serial words carry a 12-bit address followed by data, LSB first
// Notes:   Offsets are the serial register addresses
package vtc_pkg;
	localparam int unsigned ADDR_W         = 12;
	localparam int unsigned DATA_W         = 28;
	localparam logic [11:0] OFF_PAT_TOTAL  = 12'h090;
	localparam logic [11:0] OFF_SEQ_TOTAL  = 12'h091;
	localparam logic [11:0] OFF_STBY3_POL  = 12'h0e2;
	localparam logic [11:0] OFF_SWEEP_EXT  = 12'h0e6;
	localparam logic [11:0] OFF_STARTUP    = 12'h0ea;
	localparam logic [11:0] OFF_SUB_MUX    = 12'h0eb;
	localparam logic [11:0] OFF_FTRIG_CTRL = 12'h0f1;
	localparam logic [4:0]  RST_PAT_TOTAL  = 5'h00;
	localparam logic [4:0]  RST_SEQ_TOTAL  = 5'h00;
	localparam logic [24:0] RST_STBY3_POL  = 25'h0000000;
	localparam logic        RST_SWEEP_EXT  = 1'b0;
	localparam logic [9:0]  RST_STARTUP    = 10'h000;
	localparam logic [15:0] RST_SUB_MUX    = 16'h0300;
	localparam logic [3:0]  RST_FTRIG_CTRL = 4'h0;
	// Field positions
	localparam int unsigned POL_VERT_LSB   = 0;
	localparam int unsigned POL_GATE_LSB   = 13;
	localparam int unsigned POL_SUBCK      = 21;
	localparam int unsigned POL_BIAS       = 22;
	localparam int unsigned POL_MECHANICAL_SHUTTER      = 23;
	localparam int unsigned POL_STROBE     = 24;
	localparam int unsigned MUX_BIAS0_SEL  = 12;
	localparam int unsigned MUX_BIAS1_SEL  = 13;
	localparam int unsigned MUX_TEST_BIT   = 14;
	localparam int unsigned MUX_SHUT_SEL   = 15;
	localparam int unsigned FTRIG_ENABLE   = 3;
	// Standby state codes
	localparam logic [1:0]  STBY_NONE      = 2'h0;
	localparam logic [1:0]  STBY_THREE     = 2'h3;
	typedef enum logic [1:0]
	{
		RX_IDLE = 2'b00,
		RX_ADDR = 2'b01,
		RX_DATA = 2'b11
	} vtc_rx_state_t;
endpackage : vtc_pkg

// >>> verilog/vtc_serial_rx.sv
// Purpose: Three-wire serial write receiver
// Assumes: Pins synchronous to clk; data taken on rising serial clock
// Notes:   Frame ends when load rises; missing data bits read as zero
`timescale 1ns/10ps
module vtc_serial_rx
#(
	parameter int unsigned DATA_BITS = vtc_pkg::DATA_W
)
(
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       sck,
	input  wire logic                       sdata,
	input  wire logic                       sload_n,
	output logic                            wr_pulse,
	output logic [vtc_pkg::ADDR_W-1:0]      wr_addr,
	output logic [DATA_BITS-1:0]            wr_data
);
	// Polarity word needs 25 bits; the bit index is only five bits wide
	if (DATA_BITS < 25 || DATA_BITS > 32)
	begin : g_width_check
		$error("DATA_BITS must be 25 to 32");
	end

	vtc_pkg::vtc_rx_state_t          state_reg;
	logic                            sck_prev_reg;
	logic [5:0]                      count_reg;
	logic [vtc_pkg::ADDR_W-1:0]      addr_reg;
	logic [DATA_BITS-1:0]            data_reg;
	logic                            rise;

	assign rise = sck & ~sck_prev_reg;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sck_prev_reg <= 1'b0;
		else
			sck_prev_reg <= sck;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= vtc_pkg::RX_IDLE;
			count_reg <= 6'h00;
			addr_reg  <= '0;
			data_reg  <= '0;
		end
		else if (sload_n)
			state_reg <= vtc_pkg::RX_IDLE;
		else
		begin
			case (state_reg)
				vtc_pkg::RX_IDLE:
				begin
					count_reg <= 6'h00;
					data_reg  <= '0;
					state_reg <= vtc_pkg::RX_ADDR;
				end
				vtc_pkg::RX_ADDR:
				begin
					if (rise)
					begin
						addr_reg[count_reg[3:0]] <= sdata;
						if (count_reg == 6'(vtc_pkg::ADDR_W - 1))
						begin
							count_reg <= 6'h00;
							state_reg <= vtc_pkg::RX_DATA;
						end
						else
							count_reg <= count_reg + 6'h01;
					end
				end
				vtc_pkg::RX_DATA:
				begin
					if (rise && count_reg < 6'(DATA_BITS))
					begin
						data_reg[count_reg[4:0]] <= sdata;
						count_reg <= count_reg + 6'h01;
					end
				end
				default:
					state_reg <= vtc_pkg::RX_IDLE;
			endcase
		end
	end

	// Write commits when load rises after a full address
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_pulse <= 1'b0;
			wr_addr  <= '0;
			wr_data  <= '0;
		end
		else
		begin
			wr_pulse <= sload_n && state_reg == vtc_pkg::RX_DATA;
			if (sload_n && state_reg == vtc_pkg::RX_DATA)
			begin
				wr_addr <= addr_reg;
				wr_data <= data_reg;
			end
		end
	end
endmodule : vtc_serial_rx
